// >>> rtl/lcod_decoder.sv
// literal and control group decode and execute for a 14-bit instruction word
// assumes fetch presents one word a cycle; stack and port values arrive from the datapath
`timescale 1ns/1ps
`include "lcod_consts.svh"
module lcod_decoder #(
   parameter int DW = `LCOD_DATA_W,
   parameter int PW = `LCOD_PC_W
)(
   input wire logic I_REF_CLK, // instruction clock, 10 MHz
   input wire logic I_RSTN, // async reset, active low
   input wire logic [`LCOD_OP_W-1:0] I_OPCODE, // fetched instruction word
   input wire logic [PW-1:0] I_PC_PLUS1, // return address of this word
   input wire logic [PW-1:0] I_STACK_TOP, // top of return stack
   input wire logic [DW-1:0] I_PORT_PINS, // pin levels of second_io_port
   input wire logic [DW-1:0] I_PORT_LATCH, // output latch of second_io_port
   input wire logic I_PRESCALER_TIMER_ZERO_COUNT, // prescaler assigned to timer zero
   output logic [DW-1:0] O_ACC, // accumulator
   output logic O_ZERO, // zero flag
   output logic O_CARRY, // carry flag
   output logic O_DCARRY, // digit carry flag
   output logic O_WATCHDOG_EXPIRY_FLAG, // 1 = no time-out
   output logic O_POWERDOWN_FLAG, // 1 = not powered down
   output logic O_WDT_CLEAR, // pulse: reset watchdog counter
   output logic O_STANDBY, // level: standby entered
   output logic O_PC_LOAD, // pulse: load program counter
   output logic [PW-1:0] O_PC_VALUE, // program counter target
   output logic O_STACK_PUSH, // pulse: push return address
   output logic O_STACK_POP, // pulse: pop stack
   output logic [PW-1:0] O_PUSH_VALUE, // return address to push
   output logic O_GIE_SET, // pulse: re-enable interrupts
   output logic O_BUSY_NOP, // level: cycle executes as no-op
   output logic [DW-1:0] O_PORT_SOURCE, // source value for port self-modify
   output logic O_PRESCALER_CLR // pulse: clear timer zero prescaler
);
   ////////////////////////////////////////////////////////////////////////////
   // decode
   logic [DW-1:0] lit; // low literal field
   logic [PW-1:0] xfer_addr; // absolute transfer target
   logic [6:0] file_addr; // file register field
   logic file_dest; // destination bit
   lcod_pkg::lcod_state_t state_reg, state_next; // flush state
   logic [DW-1:0] acc_reg, acc_next; // accumulator
   logic z_reg, z_next, c_reg, c_next, dc_reg, dc_next; // arithmetic flags
   logic to_reg, to_next, pd_reg, pd_next; // watchdog and power status
   logic wdt_reg, wdt_next, sby_reg, sby_next; // watchdog clear, standby
   logic pcl_reg, pcl_next, push_reg, push_next, pop_reg, pop_next; // flow strobes
   logic [PW-1:0] pcv_reg, pcv_next, pushv_reg, pushv_next; // flow values
   logic gie_reg, gie_next, nop_reg, nop_next; // interrupt enable, no-op marker
   logic [DW-1:0] psrc_reg, psrc_next; // port source
   logic pclr_reg, pclr_next; // prescaler clear
   logic [DW-1:0] pin_s1_reg, pin_s1_next; // pin synchroniser, first stage
   logic [DW-1:0] pin_s2_reg, pin_s2_next; // pin synchroniser, second stage
   logic [DW-1:0] pin_s3_reg, pin_s3_next; // pin synchroniser, third stage
   logic [DW:0] diff; // literal minus accumulator, with borrow out
   logic [4:0] ndiff; // low nibble difference
   logic [DW-1:0] logic_res; // result of logic ops
   logic run; // word is live, not a flushed prefetch

   assign lit = I_OPCODE[DW-1:0];
   assign xfer_addr = {{(PW-11){1'b0}}, I_OPCODE[10:0]};
   assign file_addr = I_OPCODE[6:0];
   assign file_dest = I_OPCODE[7];

   ////////////////////////////////////////////////////////////////////////////
   // next-state computation
   always_comb
   begin
      state_next = lcod_pkg::LCOD_EXEC;
      acc_next = acc_reg;
      z_next = z_reg;
      c_next = c_reg;
      dc_next = dc_reg;
      to_next = to_reg;
      pd_next = pd_reg;
      wdt_next = 1'b0;
      sby_next = sby_reg;
      pcl_next = 1'b0;
      pcv_next = pcv_reg;
      push_next = 1'b0;
      pushv_next = pushv_reg;
      pop_next = 1'b0;
      gie_next = 1'b0;
      nop_next = 1'b0;
      pclr_next = 1'b0;
      run = (state_reg == lcod_pkg::LCOD_EXEC);
      // borrow convention: carry set means no borrow
      diff = {1'b0, lit} - {1'b0, acc_reg};
      ndiff = {1'b0, lit[3:0]} - {1'b0, acc_reg[3:0]};
      unique case (I_OPCODE[9:8])
         2'b00: logic_res = acc_reg | lit;
         2'b01: logic_res = acc_reg & lit;
         2'b10: logic_res = acc_reg ^ lit;
         default: logic_res = acc_reg;
      endcase
      // port pins arrive unclocked: three stages before anything uses them
      pin_s1_next = I_PORT_PINS;
      pin_s2_next = pin_s1_reg;
      pin_s3_next = pin_s2_reg;
      // port self-modify sources the pins, never the latch;
      // a bit moves only once the last two stages agree, so a one-cycle glitch never lands
      psrc_next = (~(pin_s2_reg ^ pin_s3_reg) & pin_s3_reg)
                  | ((pin_s2_reg ^ pin_s3_reg) & psrc_reg);
      if (!run)
      begin
         // discarded prefetch executes as no-op
         nop_next = 1'b1;
      end
      else if (I_OPCODE[13:8] == `LCOD_AND_TOP || I_OPCODE[13:8] == `LCOD_OR_TOP
               || I_OPCODE[13:8] == `LCOD_XOR_TOP)
      begin
         acc_next = logic_res;
         z_next = (logic_res == '0);
      end
      else if (I_OPCODE[13:9] == `LCOD_SUB_TOP)
      begin
         acc_next = diff[DW-1:0];
         c_next = ~diff[DW];
         dc_next = ~ndiff[4];
         z_next = (diff[DW-1:0] == '0);
      end
      else if (I_OPCODE[13:10] == `LCOD_RETLIT_TOP)
      begin
         acc_next = lit;
         pop_next = 1'b1;
         pcl_next = 1'b1;
         pcv_next = I_STACK_TOP;
         state_next = lcod_pkg::LCOD_FLUSH;
      end
      else if (I_OPCODE[13:10] == `LCOD_MOVLIT_TOP)
      begin
         acc_next = lit;
      end
      else if (I_OPCODE[13:12] == `LCOD_XFER_TOP)
      begin
         // call pushes the return address in the same cycle that the jump lands
         push_next = ~I_OPCODE[11];
         pushv_next = I_PC_PLUS1;
         pcl_next = 1'b1;
         pcv_next = xfer_addr;
         state_next = lcod_pkg::LCOD_FLUSH;
      end
      else if (I_OPCODE == `LCOD_RET_WORD || I_OPCODE == `LCOD_INTERRUPT_RETURN_OP_WORD)
      begin
         pop_next = 1'b1;
         pcl_next = 1'b1;
         pcv_next = I_STACK_TOP;
         gie_next = I_OPCODE[0];
         state_next = lcod_pkg::LCOD_FLUSH;
      end
      else if (I_OPCODE == `LCOD_WATCHDOG_CLEAR_OP_WORD)
      begin
         wdt_next = 1'b1;
         to_next = 1'b1;
         pd_next = 1'b1;
      end
      else if (I_OPCODE == `LCOD_SLEEP_WORD)
      begin
         // standby also clears the watchdog, as the core then halts
         wdt_next = 1'b1;
         to_next = 1'b1;
         pd_next = 1'b0;
         sby_next = 1'b1;
      end
      else if (((I_OPCODE[13:12] == `LCOD_FILE_TOP && file_dest)
                || I_OPCODE[13:11] == `LCOD_BITWR_TOP) && file_addr == `LCOD_TIMER_ZERO_COUNT_ADDR)
      begin
         // byte ops that write back, or bit clear/set, land on the count;
         // a word with the destination clear only reads it
         if (I_PRESCALER_TIMER_ZERO_COUNT)
         begin
            pclr_next = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge I_REF_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         state_reg <= lcod_pkg::LCOD_EXEC;
         acc_reg <= '0;
         {z_reg, c_reg, dc_reg} <= `LCOD_RST_STATUS;
         to_reg <= 1'b1;
         pd_reg <= 1'b1;
         wdt_reg <= 1'b0;
         sby_reg <= 1'b0;
         pcl_reg <= 1'b0;
         pcv_reg <= '0;
         push_reg <= 1'b0;
         pushv_reg <= '0;
         pop_reg <= 1'b0;
         gie_reg <= 1'b0;
         nop_reg <= 1'b0;
         psrc_reg <= '0;
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
         pclr_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         z_reg <= z_next;
         c_reg <= c_next;
         dc_reg <= dc_next;
         to_reg <= to_next;
         pd_reg <= pd_next;
         wdt_reg <= wdt_next;
         sby_reg <= sby_next;
         pcl_reg <= pcl_next;
         pcv_reg <= pcv_next;
         push_reg <= push_next;
         pushv_reg <= pushv_next;
         pop_reg <= pop_next;
         gie_reg <= gie_next;
         nop_reg <= nop_next;
         psrc_reg <= psrc_next;
         pin_s1_reg <= pin_s1_next;
         pin_s2_reg <= pin_s2_next;
         pin_s3_reg <= pin_s3_next;
         pclr_reg <= pclr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign O_ACC = acc_reg;
   assign O_ZERO = z_reg;
   assign O_CARRY = c_reg;
   assign O_DCARRY = dc_reg;
   assign O_WATCHDOG_EXPIRY_FLAG = to_reg;
   assign O_POWERDOWN_FLAG = pd_reg;
   assign O_WDT_CLEAR = wdt_reg;
   assign O_STANDBY = sby_reg;
   assign O_PC_LOAD = pcl_reg;
   assign O_PC_VALUE = pcv_reg;
   assign O_STACK_PUSH = push_reg;
   assign O_STACK_POP = pop_reg;
   assign O_PUSH_VALUE = pushv_reg;
   assign O_GIE_SET = gie_reg;
   assign O_BUSY_NOP = nop_reg;
   assign O_PORT_SOURCE = psrc_reg;
   assign O_PRESCALER_CLR = pclr_reg;
endmodule : lcod_decoder

// >>> rtl/lcod_consts.svh
// constants for the literal and control decoder: opcode fields, status bits, counts
// assumes a 14-bit instruction word and an 8-bit accumulator datapath
//
// Operation
// - and, or, xor literal; zero flag only
// - subtract accumulator from literal; carry, digit, zero
// - return with literal: load, pop, two cycles
// - subroutine return pops program counter, two cycles
// - interrupt return pops, re-enables interrupts
// - watchdog clear resets counter, sets expiry, powerdown
// - standby entry, one cycle, updates expiry, powerdown
// - port self-modify reads pins, not latch
// - timer zero writeback clears assigned prescaler
// - program counter change costs second no-operation cycle
`ifndef LCOD_CONSTS_SVH
`define LCOD_CONSTS_SVH
`define LCOD_OP_W 14
`define LCOD_DATA_W 8
`define LCOD_PC_W 13
`define LCOD_AND_TOP 6'h39
`define LCOD_OR_TOP 6'h38
`define LCOD_XOR_TOP 6'h3A
`define LCOD_SUB_TOP 5'h1E
`define LCOD_RETLIT_TOP 4'hD
`define LCOD_MOVLIT_TOP 4'hC
`define LCOD_RET_WORD 14'h0008
`define LCOD_INTERRUPT_RETURN_OP_WORD 14'h0009
`define LCOD_WATCHDOG_CLEAR_OP_WORD 14'h0064
`define LCOD_SLEEP_WORD 14'h0063
`define LCOD_XFER_TOP 2'h2
`define LCOD_FILE_TOP 2'h0
`define LCOD_BITWR_TOP 3'h2
`define LCOD_TIMER_ZERO_COUNT_ADDR 7'h01
`define LCOD_SECOND_IO_PORT_ADDR 7'h06
`define LCOD_RST_STATUS 3'h0
`endif

// >>> rtl/lcod_pkg.sv
// types for the literal and control decoder
// assumes lcod_consts.svh is compiled alongside
package lcod_pkg;
   // execute state: normal or flushing prefetch
   typedef enum logic [0:0]
   {
      LCOD_EXEC = 1'b0,
      LCOD_FLUSH = 1'b1
   } lcod_state_t;
endpackage : lcod_pkg

// >>> bench/lcod_decoder_chk.sv
// checker for the literal and control decoder, watching top ports only
// assumes default widths: 14-bit word, 8-bit data, 13-bit program counter
`timescale 1ns/1ps
module lcod_decoder_chk (
   input wire logic I_REF_CLK, I_RSTN, I_PRESCALER_TIMER_ZERO_COUNT, // clock, reset, prescaler owner
   input wire logic [13:0] I_OPCODE, // fetched word
   input wire logic [12:0] I_PC_PLUS1, I_STACK_TOP, O_PC_VALUE, O_PUSH_VALUE, // addresses
   input wire logic [7:0] O_ACC, // accumulator
   input wire logic O_ZERO, O_CARRY, O_WATCHDOG_EXPIRY_FLAG, O_POWERDOWN_FLAG, // status
   input wire logic O_WDT_CLEAR, O_STANDBY, O_PC_LOAD, O_STACK_PUSH, O_STACK_POP, // control
   input wire logic O_GIE_SET, O_BUSY_NOP, O_PRESCALER_CLR // pulses
);
   logic tk; // word is taken, not flushed
   assign tk = !O_PC_LOAD;
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RSTN);
   ////////////////////////////////////////////////////////////////////////////////
   property p_and; tk && I_OPCODE[13:8] == 6'h39 |=> O_ACC == ($past(O_ACC) & $past(I_OPCODE[7:0]))
      && O_ZERO == (O_ACC == 8'h00) && $stable(O_CARRY); endproperty
   a_and: assert property (p_and) else $error("and literal wrong");
   property p_sub; tk && I_OPCODE[13:9] == 5'h1E |=> {O_CARRY, O_ACC} ==
      ({1'h1, $past(I_OPCODE[7:0])} - {1'h0, $past(O_ACC)}); endproperty
   a_sub: assert property (p_sub) else $error("subtract wrong");
   property p_retlit; tk && I_OPCODE[13:10] == 4'hD |=> O_ACC == $past(I_OPCODE[7:0])
      && O_STACK_POP && O_PC_LOAD && $stable(O_ZERO); endproperty
   a_retlit: assert property (p_retlit) else $error("return with literal wrong");
   property p_ret; tk && I_OPCODE == 14'h0008 |=> O_STACK_POP && !O_GIE_SET
      && O_PC_VALUE == $past(I_STACK_TOP); endproperty
   a_ret: assert property (p_ret) else $error("return wrong");
   property p_rfie; tk && I_OPCODE == 14'h0009 |=> O_GIE_SET && O_STACK_POP && O_PC_LOAD; endproperty
   a_rfie: assert property (p_rfie) else $error("interrupt return wrong");
   property p_wdt; tk && I_OPCODE == 14'h0064 |=> O_WDT_CLEAR && O_WATCHDOG_EXPIRY_FLAG
      && O_POWERDOWN_FLAG; endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
   property p_sleep; tk && I_OPCODE == 14'h0063 |=> O_STANDBY && !O_POWERDOWN_FLAG; endproperty
   a_sleep: assert property (p_sleep) else $error("standby wrong");
   property p_presc; tk && I_OPCODE[13:12] == 2'h0 && I_OPCODE[7:0] == 8'h81 && I_PRESCALER_TIMER_ZERO_COUNT
      |=> O_PRESCALER_CLR; endproperty
   a_presc: assert property (p_presc) else $error("prescaler not cleared");
   property p_flush; $rose(O_PC_LOAD) |=> !O_PC_LOAD && O_BUSY_NOP; endproperty
   a_flush: assert property (p_flush) else $error("prefetch not flushed");
   property p_call; tk && I_OPCODE[13:11] == 3'h4 |=> O_STACK_PUSH && O_PC_LOAD
      && O_PUSH_VALUE == $past(I_PC_PLUS1) && O_PC_VALUE[10:0] == $past(I_OPCODE[10:0]); endproperty
   a_call: assert property (p_call) else $error("call wrong");
endmodule : lcod_decoder_chk
bind lcod_decoder lcod_decoder_chk u_chk (
   .I_REF_CLK(I_REF_CLK),
   .I_RSTN(I_RSTN),
   .I_PRESCALER_TIMER_ZERO_COUNT(I_PRESCALER_TIMER_ZERO_COUNT),
   .I_OPCODE(I_OPCODE),
   .I_PC_PLUS1(I_PC_PLUS1),
   .I_STACK_TOP(I_STACK_TOP),
   .O_PC_VALUE(O_PC_VALUE),
   .O_PUSH_VALUE(O_PUSH_VALUE),
   .O_ACC(O_ACC),
   .O_ZERO(O_ZERO),
   .O_CARRY(O_CARRY),
   .O_WATCHDOG_EXPIRY_FLAG(O_WATCHDOG_EXPIRY_FLAG),
   .O_POWERDOWN_FLAG(O_POWERDOWN_FLAG),
   .O_WDT_CLEAR(O_WDT_CLEAR),
   .O_STANDBY(O_STANDBY),
   .O_PC_LOAD(O_PC_LOAD),
   .O_STACK_PUSH(O_STACK_PUSH),
   .O_STACK_POP(O_STACK_POP),
   .O_GIE_SET(O_GIE_SET),
   .O_BUSY_NOP(O_BUSY_NOP),
   .O_PRESCALER_CLR(O_PRESCALER_CLR)
);

// >>> bench/lcod_far_model.sv
// fetch unit and one-deep return stack facing the decoder
// assumes the decoder's flow pulses last one cycle
`timescale 1ns/1ps
module lcod_far_model (
   input wire logic I_REF_CLK, I_RSTN, O_PC_LOAD, O_STACK_PUSH, // clock, reset, flow pulses
   input wire logic [12:0] O_PC_VALUE, O_PUSH_VALUE, // jump target, return address
   output logic [12:0] I_PC_PLUS1, I_STACK_TOP // next fetch address, stack top
);
   logic [12:0] pc_reg; // fetch address
   // advances at the falling edge so the decoder sees settled values
   always @(negedge I_REF_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         pc_reg <= 13'h0000;
         I_STACK_TOP <= 13'h1555; // arbitrary until the first push
      end
      else
      begin
         pc_reg <= O_PC_LOAD ? O_PC_VALUE : pc_reg + 13'h0001;
         if (O_STACK_PUSH) I_STACK_TOP <= O_PUSH_VALUE;
      end
   end
   assign I_PC_PLUS1 = pc_reg + 13'h0001;
endmodule : lcod_far_model

// >>> bench/test_literal_control_op_decode.sv
// testbench: one task a scenario, words driven at the falling edge
// assumes the decoder with default widths and the far-side model
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module test_literal_control_op_decode;
   logic I_REF_CLK = 0, I_RSTN = 0, I_PRESCALER_TIMER_ZERO_COUNT = 0; // clock, reset, prescaler owner
   logic [13:0] I_OPCODE = 14'h0000; // word under test
   logic [7:0] I_PORT_PINS = 8'h00, I_PORT_LATCH = 8'hFF, O_ACC, O_PORT_SOURCE; // data
   logic [12:0] I_PC_PLUS1, I_STACK_TOP, O_PC_VALUE, O_PUSH_VALUE, pc1_s, stk_s; // addresses
   logic O_ZERO, O_CARRY, O_DCARRY, O_WATCHDOG_EXPIRY_FLAG, O_POWERDOWN_FLAG, O_WDT_CLEAR;
   logic O_STANDBY, O_PC_LOAD, O_STACK_PUSH, O_STACK_POP, O_GIE_SET, O_BUSY_NOP, O_PRESCALER_CLR;
   int n_mismatch = 0, checks_done = 0, cycles = 0; // tallies
   lcod_decoder uut (.*);
   lcod_far_model far (.*);
   always #50 I_REF_CLK = ~I_REF_CLK;
   ////////////////////////////////////////////////////////////////////////////////
   // one word: held over the sampling edge, effects settled at the next falling edge
   task automatic op(input logic [13:0] w);
      I_OPCODE = w;
      @(posedge I_REF_CLK);
      pc1_s = I_PC_PLUS1;
      stk_s = I_STACK_TOP;
      @(negedge I_REF_CLK);
   endtask : op
   task automatic t_alu;
      op(14'h30F0); op(14'h393C); `CHK("and", 8'h30, O_ACC)
      op(14'h380F); `CHK("or", 8'h3F, O_ACC)
      op(14'h3A3F); `CHK("xor", 8'h00, O_ACC) `CHK("zero", 1'h1, O_ZERO)
      op(14'h3005); `CHK("load", 8'h05, O_ACC) `CHK("zero kept", 1'h1, O_ZERO)
      op(14'h3C03); `CHK("sub", 11'h0FE, {O_CARRY, O_DCARRY, O_ZERO, O_ACC})
      op(14'h3003); op(14'h3D03); `CHK("sub eq", 11'h700, {O_CARRY, O_DCARRY, O_ZERO, O_ACC})
      op(14'h3001); op(14'h3C10); `CHK("sub dc", 11'h40F, {O_CARRY, O_DCARRY, O_ZERO, O_ACC})
      $display("alu test done");
   endtask : t_alu
   task automatic t_flow;
      op(14'h2005); `CHK("push", 14'h2005, {O_STACK_PUSH, O_PC_VALUE})
      `CHK("push value", pc1_s, O_PUSH_VALUE)
      op(14'h2807); `CHK("flush", 2'h1, {O_PC_LOAD, O_BUSY_NOP})
      op(14'h0008); `CHK("return", {1'h1, stk_s}, {O_STACK_POP, O_PC_VALUE})
      op(14'h0000); op(14'h3455); `CHK("retlit", 9'h155, {O_STACK_POP, O_ACC})
      op(14'h0000); op(14'h0009); `CHK("gie", 2'h3, {O_GIE_SET, O_PC_LOAD})
      op(14'h0000); op(14'h2ABC); `CHK("jump", 12'hABC, {O_PC_LOAD, O_PC_VALUE[10:0]})
      op(14'h0000);
      $display("flow test done");
   endtask : t_flow
   task automatic t_port;
      I_PORT_PINS = 8'h5A;
      repeat (3) op(14'h0000); // pins pass the synchroniser first
      op(14'h0886); `CHK("port source", 8'h5A, O_PORT_SOURCE)
      I_PRESCALER_TIMER_ZERO_COUNT = 1'h1;
      op(14'h0881); `CHK("presc clr", 1'h1, O_PRESCALER_CLR)
      op(14'h0801); `CHK("presc d0", 1'h0, O_PRESCALER_CLR)
      op(14'h0101); `CHK("presc clear w", 1'h0, O_PRESCALER_CLR)
      op(14'h1481); `CHK("presc bit set", 1'h1, O_PRESCALER_CLR)
      I_PRESCALER_TIMER_ZERO_COUNT = 1'h0;
      op(14'h0881); `CHK("presc other", 1'h0, O_PRESCALER_CLR)
      $display("port test done");
   endtask : t_port
   task automatic t_power;
      op(14'h0063); `CHK("standby", 3'h5, {O_STANDBY, O_POWERDOWN_FLAG, O_WATCHDOG_EXPIRY_FLAG})
      op(14'h0064); `CHK("wdt clr", 4'hF, {O_STANDBY, O_WDT_CLEAR, O_POWERDOWN_FLAG,
         O_WATCHDOG_EXPIRY_FLAG})
      $display("power test done");
   endtask : t_power
   task conclude;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // hang guard, far above the fifty or so cycles the run needs
   always @(posedge I_REF_CLK)
   begin
      cycles++;
      if (cycles == 500)
      begin
         n_mismatch++;
         conclude;
      end
   end
   initial
   begin
      repeat (20) @(negedge I_REF_CLK);
      `CHK("reset flags", 10'h300, {O_WATCHDOG_EXPIRY_FLAG, O_POWERDOWN_FLAG, O_ACC})
      I_RSTN = 1'h1;
      t_alu;
      t_flow;
      t_port;
      t_power;
      conclude;
   end
endmodule : test_literal_control_op_decode
